// >>> inc/dpar_map.svh
// Constants for the dynamic phase alignment receiver
`ifndef DPAR_MAP_SVH
`define DPAR_MAP_SVH
`define DPAR_PHASES 8
`define DPAR_PH_W 3
`define DPAR_PH_LAST 3'h7
`define DPAR_MID_EYE 3'h4
`define DPAR_BYP_PHASE 3'h4
`define DPAR_W_MULT 1
`define DPAR_J 10
`define DPAR_J_W 4
`define DPAR_CH 4
`define DPAR_MAX_CH 20
`define DPAR_SYNC_DEPTH 4
`define DPAR_SYNC_AW 2
`define DPAR_WPTR_RST 2'h2
`define DPAR_RPTR_RST 2'h0
`define DPAR_PRIME_CNT 2'h2
`define DPAR_OUT_DEPTH 16
`define DPAR_CLK_PS 25000
`define DPAR_RATE_DPA_MBPS 1000
`define DPAR_RATE_BYP_MBPS 840
`endif

// >>> inc/dpar_pkg.sv
// Types for the dynamic phase alignment receiver
`include "dpar_map.svh"
package dpar_pkg;
    typedef logic [`DPAR_PH_W-1:0] dpar_phase_t;
    typedef logic [`DPAR_J-1:0] dpar_word_t;
    typedef struct packed {
        dpar_word_t [`DPAR_CH-1:0] data;
    } dpar_frame_t;
    typedef struct packed {
        dpar_phase_t [`DPAR_CH-1:0] phase;
        logic [`DPAR_CH-1:0] edge_seen;
    } dpar_status_t;
endpackage

// >>> src/dpar_receiver.sv
// Dynamic phase alignment receiver with per-channel synchronizers and output FIFO
//
// Contract
// [RULE1] Eight equal phases from four-stage oscillator
// [RULE2] Lock nearest phase, forward retimed data
// [RULE3] Each channel picks its phase independently
// [RULE4] Alignment automatic, continuous, tracks drift
// [RULE5] Phase step is one eighth bit
// [RULE6] Each fast edge measures and adjusts phase
// [RULE7] Source clock multiplied by W to bitrate
// [RULE8] Sender repeats ten zeros ten ones 256x
// [RULE9] Sender trains with 00001111 or 10010000
// [RULE10] Sender trains with alternating ones and zeros
// [RULE11] Each receiver has own phase synchronizer
// [RULE12] Synchronizer FIFO four deep, J wide
// [RULE13] Written on parallel clock, read global
// [RULE14] Parallel and global clocks share frequency
// [RULE15] No flags or enables; every-cycle transfer
// [RULE16] Receiver pins are inputs only
// [RULE17] Up to 1000 Mbps aligned, 840 bypassed
// [RULE18] Only centre PLL drives aligned channels
// [RULE19] At most 20 channels per direction
// [RULE20] J restricted to 8 or 10
// [RULE21] Synchronizer pointers start two entries apart
`timescale 1ns/1ps
`include "dpar_map.svh"

module dpar_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rptr_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("output fifo written while full");
endmodule

module dpar_receiver (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic src_clk_i,
    input wire logic [`DPAR_CH-1:0] rx_serial_i,
    input wire logic bypass_i,
    input wire logic centre_pll_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output dpar_pkg::dpar_frame_t out_frame_o,
    output logic accept_o,
    output logic drop_o,
    output dpar_pkg::dpar_status_t status_o
);
    import dpar_pkg::*;

    localparam int CH = `DPAR_CH;
    localparam int BIT_PS = `DPAR_PHASES * `DPAR_CLK_PS;
    localparam int RATE_MBPS = 1000000 / BIT_PS;

    logic src_s1_r;
    logic src_s2_r;
    logic src_s3_r;
    logic src_rise;
    dpar_phase_t ph_r;
    logic align_en;
    logic [`DPAR_J_W-1:0] gbit_r;
    logic gce_r;
    logic [`DPAR_SYNC_AW-1:0] rptr_r;
    logic [1:0] prime_r;
    dpar_frame_t frame_r;
    logic frame_vld_r;
    logic push_ready;
    logic drop_r;

    logic [CH-1:0] ser_s1_r;
    logic [CH-1:0] ser_s2_r;
    logic [CH-1:0][`DPAR_PHASES-2:0] samp_r;
    logic [CH-1:0] last_r;
    dpar_phase_t [CH-1:0] sel_r;
    logic [CH-1:0] seen_r;
    logic [CH-1:0] bit_r;
    logic [CH-1:0] bit_ce_r;
    logic [CH-1:0][`DPAR_J-1:0] shift_r;
    logic [CH-1:0][`DPAR_J_W-1:0] bcnt_r;
    logic [CH-1:0] wr_ce_r;
    logic [CH-1:0][`DPAR_SYNC_AW-1:0] wptr_r;
    dpar_word_t [CH-1:0] sync_q_r;

    // Source clock pin is sampled twice before the edge finder reads it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            src_s1_r <= 1'b0;
            src_s2_r <= 1'b0;
            src_s3_r <= 1'b0;
        end else begin
            src_s1_r <= src_clk_i; // [RULE7]
            src_s2_r <= src_s1_r;
            src_s3_r <= src_s2_r;
        end
    end
    assign src_rise = src_s2_r && !src_s3_r;

    // Eight taps per bit; a source edge every W bits re-locks tap zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ph_r <= '0;
        end else if (src_rise) begin
            ph_r <= '0; // [RULE7]
        end else begin
            ph_r <= ph_r + 1'b1; // [RULE1]
        end
    end

    // Corner PLLs cannot align, so they fall back to the fixed tap
    assign align_en = centre_pll_i && !bypass_i; // [RULE18]

    genvar c;
    generate
        for (c = 0; c < CH; c++) begin : g_ch
            logic [`DPAR_PHASES-1:0] win;
            dpar_phase_t edge_ph;
            logic edge_hit;
            dpar_phase_t target;
            dpar_phase_t diff;

            // Receiver pins are only ever read
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    ser_s1_r[c] <= 1'b0;
                    ser_s2_r[c] <= 1'b0;
                end else begin
                    ser_s1_r[c] <= rx_serial_i[c]; // [RULE16]
                    ser_s2_r[c] <= ser_s1_r[c];
                end
            end

            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    samp_r[c] <= '0;
                    last_r[c] <= 1'b0;
                end else if (ph_r == `DPAR_PH_LAST) begin
                    last_r[c] <= ser_s2_r[c];
                end else begin
                    samp_r[c][ph_r] <= ser_s2_r[c];
                end
            end

            // Find the first data transition inside the current bit
            always_comb begin
                win = {ser_s2_r[c], samp_r[c]};
                edge_hit = 1'b0;
                edge_ph = '0;
                if (win[0] != last_r[c]) begin
                    edge_hit = 1'b1;
                end else begin
                    for (int k = 1; k < `DPAR_PHASES; k++) begin
                        if (!edge_hit && (win[k] != win[k-1])) begin
                            edge_hit = 1'b1;
                            edge_ph = dpar_phase_t'(k);
                        end
                    end
                end
                target = edge_ph + `DPAR_MID_EYE;
                diff = target - sel_r[c];
            end

            // One-tap steps keep drift tracking smooth but take up to four bits with a data transition to settle
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    sel_r[c] <= `DPAR_BYP_PHASE;
                    seen_r[c] <= 1'b0;
                end else if (!align_en) begin
                    sel_r[c] <= `DPAR_BYP_PHASE; // [RULE17]
                end else if (ph_r == `DPAR_PH_LAST && edge_hit) begin // [RULE6] [RULE4]
                    seen_r[c] <= 1'b1;
                    if (diff != '0) begin
                        sel_r[c] <= diff[`DPAR_PH_W-1] && (diff != `DPAR_MID_EYE)
                            ? sel_r[c] - 1'b1 : sel_r[c] + 1'b1; // [RULE5] [RULE3]
                    end
                end
            end

            // A tap move across the bit edge may repeat or skip one bit
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    bit_r[c] <= 1'b0;
                    bit_ce_r[c] <= 1'b0;
                end else begin
                    bit_ce_r[c] <= (ph_r == sel_r[c]); // [RULE2]
                    if (ph_r == sel_r[c]) begin
                        bit_r[c] <= ser_s2_r[c];
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    shift_r[c] <= '0;
                    bcnt_r[c] <= '0;
                    wr_ce_r[c] <= 1'b0;
                end else begin
                    wr_ce_r[c] <= 1'b0;
                    if (bit_ce_r[c]) begin
                        shift_r[c] <= {shift_r[c][`DPAR_J-2:0], bit_r[c]};
                        if (bcnt_r[c] == `DPAR_J_W'(`DPAR_J-1)) begin
                            bcnt_r[c] <= '0;
                            wr_ce_r[c] <= 1'b1;
                        end else begin
                            bcnt_r[c] <= bcnt_r[c] + 1'b1;
                        end
                    end
                end
            end

            // Frequency lock keeps this FIFO from wrapping, so it has no flags
            dpar_word_t mem_r [`DPAR_SYNC_DEPTH];
            always_ff @(posedge clk_i) begin
                if (wr_ce_r[c]) begin
                    mem_r[wptr_r[c]] <= shift_r[c]; // [RULE12] [RULE11]
                end
            end

            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    wptr_r[c] <= `DPAR_WPTR_RST; // [RULE21]
                end else if (wr_ce_r[c]) begin
                    wptr_r[c] <= wptr_r[c] + 1'b1; // [RULE13] [RULE15]
                end
            end

            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    sync_q_r[c] <= '0;
                end else if (gce_r) begin
                    sync_q_r[c] <= mem_r[rptr_r]; // [RULE13]
                end
            end

            a_sel_one_tap: assert property (@(posedge clk_i) disable iff (!rstn_i)
                align_en && $past(align_en) && sel_r[c] != $past(sel_r[c]) |->
                (sel_r[c] == $past(sel_r[c]) + 1'b1 || sel_r[c] == $past(sel_r[c]) - 1'b1)) // [RULE5]
                else $error("selected tap moved more than one step");
            a_adjust_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
                align_en && $past(align_en) && sel_r[c] != $past(sel_r[c]) |->
                $past(ph_r) == `DPAR_PH_LAST) // [RULE6]
                else $error("tap moved away from the bit boundary");
            a_retime_tap: assert property (@(posedge clk_i) disable iff (!rstn_i)
                (ph_r == sel_r[c]) |=> bit_ce_r[c] && bit_r[c] == $past(ser_s2_r[c])) // [RULE2]
                else $error("retimed bit not taken at selected tap");
            a_word_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
                wr_ce_r[c] |=> !wr_ce_r[c] [*7]) // [RULE15]
                else $error("synchronizer written faster than one word per bit span");
        end
    endgenerate

    // Global read clock: one word per J bit periods, common to all channels
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gbit_r <= '0;
            gce_r <= 1'b0;
        end else begin
            gce_r <= 1'b0;
            if (ph_r == `DPAR_PH_LAST) begin
                if (gbit_r == `DPAR_J_W'(`DPAR_J-1)) begin
                    gbit_r <= '0;
                    gce_r <= 1'b1; // [RULE14]
                end else begin
                    gbit_r <= gbit_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rptr_r <= `DPAR_RPTR_RST; // [RULE21]
            prime_r <= '0;
        end else if (gce_r) begin
            rptr_r <= rptr_r + 1'b1; // [RULE15]
            if (prime_r != `DPAR_PRIME_CNT) begin
                prime_r <= prime_r + 1'b1;
            end
        end
    end

    // First reads return stale entries; hold the stream until two words passed
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            frame_r <= '0;
            frame_vld_r <= 1'b0;
        end else begin
            frame_vld_r <= gce_r && (prime_r == `DPAR_PRIME_CNT);
            if (gce_r) begin
                for (int k = 0; k < CH; k++) begin
                    frame_r.data[k] <= mem_rd(k);
                end
            end
        end
    end

    function automatic dpar_word_t mem_rd(input int k);
        mem_rd = sync_q_r[k];
    endfunction

    // The link cannot stall, so a full output FIFO loses the frame and says so
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            drop_r <= 1'b0;
        end else if (frame_vld_r && !push_ready) begin
            drop_r <= 1'b1;
        end
    end

    dpar_fifo #(
        .WIDTH($bits(dpar_frame_t)),
        .DEPTH(`DPAR_OUT_DEPTH)
    ) u_out_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(frame_vld_r),
        .in_ready_o(push_ready),
        .in_data_i(frame_r),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o(out_frame_o)
    );

    assign accept_o = push_ready;
    assign drop_o = drop_r;
    assign status_o.phase = sel_r;
    assign status_o.edge_seen = seen_r;

    a_tap_advance: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !src_rise |=> ph_r == $past(ph_r) + 1'b1) // [RULE1]
        else $error("phase taps did not advance in order");
    a_src_relock: assert property (@(posedge clk_i) disable iff (!rstn_i)
        src_rise |=> ph_r == '0) // [RULE7]
        else $error("source edge did not re-lock tap zero");
    a_bypass_fixed: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !align_en |=> status_o.phase[0] == `DPAR_BYP_PHASE) // [RULE18]
        else $error("tap moved while alignment unavailable");
    a_global_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gce_r |=> !gce_r [*8]) // [RULE14]
        else $error("global read strobe too frequent");
    a_ptr_gap: assert property (@(posedge clk_i)
        !rstn_i |=> rptr_r == `DPAR_RPTR_RST && wptr_r[0] == `DPAR_WPTR_RST) // [RULE21]
        else $error("synchronizer pointers not two apart after reset");
    a_width_legal: assert property (@(posedge clk_i) disable iff (!rstn_i)
        `DPAR_J == 8 || `DPAR_J == 10) // [RULE20]
        else $error("word width must be 8 or 10");
    a_chan_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        CH <= `DPAR_MAX_CH) // [RULE19]
        else $error("too many channels on one fast PLL");
    a_rate_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        RATE_MBPS <= (align_en ? `DPAR_RATE_DPA_MBPS : `DPAR_RATE_BYP_MBPS)) // [RULE17]
        else $error("line rate above supported limit");
endmodule

// >>> tb/dpar_tx_model.sv
// Behavioural source-synchronous transmitter forwarding its clock
`timescale 1ns/1ps
module dpar_tx_model (
    input wire logic en_i,
    input wire logic [1:0] mode_i,
    input wire logic [5:0] skew_i,
    output logic src_clk_o,
    output logic [3:0] serial_o
);
    longint step;
    longint n;
    function automatic logic pat(input logic [1:0] m, input longint b);
        case (m)
            2'h0: return b[0];
            2'h1: return (b % 20) >= 10;
            2'h2: return (b % 8) >= 4;
            default: return (b % 8 == 0) || (b % 8 == 3);
        endcase
    endfunction
    initial begin
        step = 1000;
        src_clk_o = 1'b0;
        serial_o = 4'h0;
        #7;
        forever begin
            #12.5;
            step++;
            // One bit per source period, multiplier of one
            src_clk_o = en_i && ((step % 16) < 8);
            for (int k = 0; k < 4; k++) begin
                // Channel k lags by two taps more than its neighbour
                n = (step - longint'(skew_i) - 4 * k) / 16;
                if (!en_i) begin
                    // Idle lines keep moving so a stale level never passes
                    serial_o[k] = ~serial_o[k];
                end else begin
                    serial_o[k] = pat(mode_i, n) ^ ((mode_i == 2'h0) && k[0]);
                end
            end
        end
    end
endmodule

// >>> tb/dpar_receiver_tb.sv
// Self-checking bench for the phase alignment receiver
`timescale 1ns/1ps
`include "dpar_map.svh"
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module dpar_receiver_tb;
    import dpar_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic bypass_i = 1'b0;
    logic centre_pll_i = 1'b1;
    logic out_ready_i = 1'b0;
    logic tx_en = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [5:0] skew = 6'h00;
    logic [1:0] m_cur;
    logic [2:0] ph_old;
    wire logic src_clk_i;
    wire logic [3:0] rx_serial_i;
    logic out_valid_o;
    logic accept_o;
    logic drop_o;
    dpar_frame_t out_frame_o;
    dpar_status_t status_o;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int pops = 0;
    int seed;
    logic [1:0] exp_q[$];

    dpar_tx_model i_tx (.en_i(tx_en), .mode_i(mode), .skew_i(skew),
        .src_clk_o(src_clk_i), .serial_o(rx_serial_i));
    dpar_receiver i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .src_clk_i(src_clk_i),
        .rx_serial_i(rx_serial_i), .bypass_i(bypass_i), .centre_pll_i(centre_pll_i),
        .out_ready_i(out_ready_i), .out_valid_o(out_valid_o), .out_frame_o(out_frame_o),
        .accept_o(accept_o), .drop_o(drop_o), .status_o(status_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic logic word_ok(input dpar_word_t w, input logic [1:0] m);
        int t = 0;
        for (int i = 0; i < 9; i++) t += (w[i] != w[i+1]);
        case (m)
            2'h0: return (w == 10'h2AA) || (w == 10'h155);
            2'h1: return t <= 1;
            2'h2: return (w[9:8] == w[1:0]) && ($countones(w[7:0]) == 4);
            default: return (w[9:8] == w[1:0]) && ($countones(w[7:0]) == 2);
        endcase
    endfunction

    // One tap of slack either way, since edges are sampled on the slow clock
    function automatic logic near(input logic [2:0] d, input logic [2:0] want);
        logic [2:0] e = d - want;
        return (e == 3'h0) || (e == 3'h1) || (e == 3'h7);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic stop_test();
        $display("miscompares %0d n_compared %0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 60000) begin
            miscompares++;
            stop_test();
        end
    end

    // Watches popped frames and checks each one popped while a note is queued against the oldest note
    always @(posedge clk_i) begin
        if (rstn_i && out_valid_o && out_ready_i) begin
            pops++;
            if (exp_q.size() > 0) begin
                m_cur = exp_q.pop_front();
                for (int k = 0; k < `DPAR_CH; k++) begin
                    `CHK(word_ok(out_frame_o.data[k], m_cur), 1'b1)
                end
            end
        end
    end

    task automatic run_mode(input logic [1:0] m, input int nf);
        @(posedge clk_i);
        mode <= m;
        tx_en <= 1'b1;
        out_ready_i <= 1'b1;
        // Settle the taps and flush frames captured while training
        cyc(800);
        repeat (nf) exp_q.push_back(m);
        for (int i = 0; i < nf * 80 + 400 && exp_q.size() > 0; i++) cyc(1);
        `CHK(exp_q.size() == 0, 1'b1)
        for (int k = 0; k < `DPAR_CH; k++) begin
            `CHK(status_o.edge_seen[k], 1'b1)
            `CHK(near(status_o.phase[k] - status_o.phase[0], 3'(2 * k)), 1'b1)
        end
    endtask

    initial begin
        seed = 8;
        skew = 6'($random(seed) & 32'h0000_000F);
        cyc(20);
        rstn_i <= 1'b1;
        cyc(2);
        `CHK(out_valid_o, 1'b0)
        `CHK(accept_o, 1'b1)
        `CHK(drop_o, 1'b0)
        `CHK(status_o, {12'h924, 4'h0})
        for (int m = 0; m < 4; m++) run_mode(2'(m), 6);
        // Drift all lanes by two taps and expect the lane 0 selection to follow
        ph_old = status_o.phase[0];
        skew <= skew + 6'h04;
        cyc(200);
        `CHK(near(status_o.phase[0] - ph_old, 3'h2), 1'b1)
        bypass_i <= 1'b1;
        cyc(400);
        for (int k = 0; k < `DPAR_CH; k++) `CHK(status_o.phase[k], `DPAR_BYP_PHASE)
        bypass_i <= 1'b0;
        centre_pll_i <= 1'b0;
        cyc(400);
        for (int k = 0; k < `DPAR_CH; k++) `CHK(status_o.phase[k], `DPAR_BYP_PHASE)
        centre_pll_i <= 1'b1;
        // Stall the consumer until the output buffer refuses
        out_ready_i <= 1'b0;
        for (int i = 0; i < 2000 && accept_o !== 1'b0; i++) cyc(1);
        `CHK(accept_o, 1'b0)
        cyc(200);
        `CHK(drop_o, 1'b1)
        pops = 0;
        for (int i = 0; i < 3000 && out_valid_o !== 1'b0; i++) begin
            @(posedge clk_i);
            out_ready_i <= $random(seed) & 32'h0000_0001;
        end
        `CHK(pops >= `DPAR_OUT_DEPTH, 1'b1)
        `CHK(drop_o, 1'b1)
        stop_test();
    end
endmodule
